/* logic/rcf_pkg.sv */
// Behaviour
// - Selectable bucks use primary code when select pin low, alternate when high.
// - All bucks start at their default level code after reset.
// - Host write to the currently selected level register updates that regulator.
// - Level code bits [5:3] pick coarse range, [2:0] pick step; 0.600 to 3.900 V.
// - Each regulator is enabled or disabled by its host-written on bit.
// - Buck power-good bit reads 0 while output is below threshold, nominally 7%.
// - Linear power-good bit reads 0 while output is below threshold, nominally 11%.
// - With fault unmask set, a regulator dropping below threshold raises the interrupt.
// - Interrupt stays low until regulator off or good again and power-good read.
// - Linear output discharges on disable only when its discharge bit is 1.
// - Serial slave at 7-bit address 1011010, up to fast mode; outside this block.
package rcf_pkg;
	localparam int NUM_BUCK      = 4;
	localparam int NUM_LDO       = 8;
	localparam int NUM_REG       = NUM_BUCK + NUM_LDO;
	localparam int CODE_W        = 6;
	localparam int ADDR_W        = 6;
	localparam int COARSE_MSB    = 5;
	localparam int COARSE_LSB    = 3;
	localparam int STEP_MSB      = 2;
	localparam int STEP_LSB      = 0;
	localparam int BUCK_GOOD_PCT = 7;
	localparam int LDO_GOOD_PCT  = 11;
	// Millivolt table, index is coarse range; step size per range
	localparam logic [11:0] RANGE_BASE_MV [8] = '{12'd600, 12'd800, 12'd1000, 12'd1200,
		12'd1600, 12'd2000, 12'd2400, 12'd3200};
	localparam logic [7:0] RANGE_STEP_MV [8] = '{8'd25, 8'd25, 8'd25, 8'd50,
		8'd50, 8'd50, 8'd100, 8'd100};
	// Register word offsets (byte address = 4 * index)
	localparam logic [ADDR_W-1:0] OFS_PRIMARY  = 6'h00; // +r, r = 0..3
	localparam logic [ADDR_W-1:0] OFS_ALT      = 6'h04; // +r
	localparam logic [ADDR_W-1:0] OFS_LINEAR   = 6'h08; // +l, l = 0..7
	localparam logic [ADDR_W-1:0] OFS_ON       = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_UNMASK   = 6'h11;
	localparam logic [ADDR_W-1:0] OFS_DISCH    = 6'h12;
	localparam logic [ADDR_W-1:0] OFS_GOOD     = 6'h13;
	localparam logic [ADDR_W-1:0] OFS_STATUS   = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 6'h15;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 6'h16;
	localparam logic [ADDR_W-1:0] OFS_SELECT   = 6'h17;
	localparam logic [ADDR_W-1:0] OFS_MV_BASE  = 6'h18; // +r, active level in mV
	localparam logic [CODE_W-1:0] RST_LEVEL    = 6'h18;
	localparam logic [NUM_REG-1:0] RST_ON      = 12'hfff;
	localparam logic [31:0] UNMAPPED_DATA      = 32'h00000000;
	localparam logic [1:0]  EV_W               = 2'd2;
endpackage

/* logic/rcf_level_decode.sv */
module rcf_level_decode
	import rcf_pkg::*;
(
	input  wire logic [CODE_W-1:0] levelCode,
	output logic      [11:0]       levelMv
);
	logic [2:0]  coarse;
	logic [2:0]  step;
	logic [11:0] stepMv;
	always_comb begin
		coarse  = levelCode[COARSE_MSB:COARSE_LSB];
		step    = levelCode[STEP_MSB:STEP_LSB];
		stepMv  = 12'(RANGE_STEP_MV[coarse]) * 12'(step);
		levelMv = RANGE_BASE_MV[coarse] + stepMv;
	end
endmodule

/* logic/rcf_top.sv */
module rcf_top
	import rcf_pkg::*;
#(
	parameter logic [CODE_W-1:0] DEF_LEVEL = RST_LEVEL
)(
	input  wire logic                        sys_clk,
	input  wire logic                        reset,
	input  wire logic [ADDR_W-1:0]           avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output logic      [31:0]                 avs_readdata,
	output logic                             avs_waitrequest,
	input  wire logic [NUM_BUCK-1:0]         level_select_pin,
	input  wire logic [rcf_pkg::NUM_REG-1:0] belowGoodRaw,
	output logic      [NUM_BUCK-1:0][CODE_W-1:0] activeLevelCode,
	output logic      [NUM_LDO-1:0][CODE_W-1:0]  linear_level_code,
	output logic      [rcf_pkg::NUM_REG-1:0] regulatorOn,
	output logic      [NUM_LDO-1:0]          dischargeOn,
	output logic                             irq_out_n,
	output logic                             irq
);
	import rcf_pkg::*;

	// Pins from analog comparators and board straps are asynchronous
	logic [NUM_BUCK-1:0] selMeta_q, selSync_q;
	logic [NUM_REG-1:0]  lowMeta_q, lowSync_q;

	logic [NUM_BUCK-1:0][CODE_W-1:0] primary_level_code_q, primary_level_code_d;
	logic [NUM_BUCK-1:0][CODE_W-1:0] alternate_level_code_q, alternate_level_code_d;
	logic [NUM_LDO-1:0][CODE_W-1:0]  linCode_q, linCode_d;
	logic [NUM_REG-1:0] on_q, on_d;
	logic [NUM_REG-1:0] fault_irq_unmask_q, fault_irq_unmask_d;
	logic [NUM_LDO-1:0] output_discharge_bit_q, output_discharge_bit_d;
	logic [NUM_REG-1:0] faultHeld_q, faultHeld_d;
	logic [NUM_REG-1:0] goodReadSeen_q, goodReadSeen_d;
	logic [1:0]         status_q, status_d;
	logic [1:0]         irqEn_q, irqEn_d;
	logic [31:0]        rdata_q, rdata_d;
	logic               ack_q, ack_d;
	logic [NUM_BUCK-1:0][11:0] levelMv;

	logic [NUM_REG-1:0] goodNow;
	logic [NUM_REG-1:0] okBits;
	logic [NUM_REG-1:0] faultRise;
	logic [NUM_REG-1:0] lowPrev_q;
	logic               wrEn, rdEn, goodRead;
	logic [1:0]         evt;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			selMeta_q <= '0;
			selSync_q <= '0;
			lowMeta_q <= '0;
			lowSync_q <= '0;
			lowPrev_q <= '0;
		end else begin
			selMeta_q <= level_select_pin;
			selSync_q <= selMeta_q;
			lowMeta_q <= belowGoodRaw;
			lowSync_q <= lowMeta_q;
			lowPrev_q <= lowSync_q & on_q;
		end
	end

	// One wait state per access: ack rises the cycle after the request
	// Writes land on the accepting edge, one after the wait state ends; reads look up one cycle early
	// Serial slave front end sits outside and drives this bus
	assign wrEn            = avs_write & ack_q;
	assign rdEn            = avs_read & ~ack_q;
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign avs_readdata    = rdata_q;
	assign goodRead        = rdEn & (avs_address == OFS_GOOD);

	// Readable bits follow the comparator; an off output sits below threshold too
	assign okBits    = ~lowSync_q;
	// Release condition: switched off or back in regulation
	assign goodNow   = okBits | ~on_q;
	assign faultRise = lowSync_q & on_q & ~lowPrev_q;

	always_comb begin
		primary_level_code_d   = primary_level_code_q;
		alternate_level_code_d = alternate_level_code_q;
		linCode_d              = linCode_q;
		on_d                   = on_q;
		fault_irq_unmask_d     = fault_irq_unmask_q;
		output_discharge_bit_d = output_discharge_bit_q;
		irqEn_d                = irqEn_q;
		status_d               = status_q;
		ack_d                  = (avs_read | avs_write) & ~ack_q;
		rdata_d                = rdata_q;
		if (wrEn && avs_byteenable[0]) begin
			for (int r = 0; r < NUM_BUCK; r++) begin
				// Host writes whichever bank the pin currently selects
				if (avs_address == OFS_PRIMARY + ADDR_W'(r) && !selSync_q[r])
					primary_level_code_d[r] = avs_writedata[CODE_W-1:0];
				if (avs_address == OFS_ALT + ADDR_W'(r) && selSync_q[r])
					alternate_level_code_d[r] = avs_writedata[CODE_W-1:0];
			end
			for (int l = 0; l < NUM_LDO; l++) begin
				if (avs_address == OFS_LINEAR + ADDR_W'(l))
					linCode_d[l] = avs_writedata[CODE_W-1:0];
			end
			if (avs_address == OFS_DISCH)
				output_discharge_bit_d = avs_writedata[NUM_LDO-1:0];
			if (avs_address == OFS_IRQ_EN)
				irqEn_d = avs_writedata[1:0];
		end
		if (wrEn && avs_byteenable[1:0] == 2'b11) begin
			if (avs_address == OFS_ON)
				on_d = avs_writedata[NUM_REG-1:0];
			if (avs_address == OFS_UNMASK)
				fault_irq_unmask_d = avs_writedata[NUM_REG-1:0];
		end
		// Status: bit0 an unmasked fault began, bit1 a fault pending was cleared
		if (wrEn && avs_address == OFS_IRQ_CLR && avs_byteenable[0])
			status_d = status_q & ~avs_writedata[1:0];
		status_d = status_d | evt; // set wins over clear
		if (rdEn) begin
			rdata_d = UNMAPPED_DATA;
			for (int r = 0; r < NUM_BUCK; r++) begin
				if (avs_address == OFS_PRIMARY + ADDR_W'(r))
					rdata_d = 32'(primary_level_code_q[r]);
				if (avs_address == OFS_ALT + ADDR_W'(r))
					rdata_d = 32'(alternate_level_code_q[r]);
				if (avs_address == OFS_MV_BASE + ADDR_W'(r))
					rdata_d = 32'(levelMv[r]);
			end
			for (int l = 0; l < NUM_LDO; l++) begin
				if (avs_address == OFS_LINEAR + ADDR_W'(l))
					rdata_d = 32'(linCode_q[l]);
			end
			case (avs_address)
				OFS_ON:      rdata_d = 32'(on_q);
				OFS_UNMASK:  rdata_d = 32'(fault_irq_unmask_q);
				OFS_DISCH:   rdata_d = 32'(output_discharge_bit_q);
				OFS_GOOD:    rdata_d = 32'(okBits);
				OFS_STATUS:  rdata_d = 32'(status_q);
				OFS_IRQ_EN:  rdata_d = 32'(irqEn_q);
				OFS_SELECT:  rdata_d = 32'(selSync_q);
				default:     rdata_d = rdata_d;
			endcase
		end
	end

	// Fault latch: set by unmasked drop, held until recovered/off and good bits read
	always_comb begin
		faultHeld_d    = faultHeld_q;
		goodReadSeen_d = goodReadSeen_q;
		for (int i = 0; i < NUM_REG; i++) begin
			if (faultHeld_q[i] && goodRead)
				goodReadSeen_d[i] = 1'b1;
			if (faultHeld_q[i] && goodReadSeen_d[i] && goodNow[i]) begin
				faultHeld_d[i]    = 1'b0;
				goodReadSeen_d[i] = 1'b0;
			end
			if (fault_irq_unmask_q[i] && faultRise[i]) begin
				faultHeld_d[i]    = 1'b1;
				goodReadSeen_d[i] = 1'b0;
			end
		end
	end
	assign evt = {|(faultHeld_q & ~faultHeld_d), |(fault_irq_unmask_q & faultRise)};

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			primary_level_code_q   <= {NUM_BUCK{DEF_LEVEL}};
			alternate_level_code_q <= {NUM_BUCK{DEF_LEVEL}};
			linCode_q              <= {NUM_LDO{DEF_LEVEL}};
			on_q                   <= RST_ON;
			fault_irq_unmask_q     <= '0;
			output_discharge_bit_q <= '0;
			faultHeld_q            <= '0;
			goodReadSeen_q         <= '0;
			status_q               <= '0;
			irqEn_q                <= '0;
			rdata_q                <= '0;
			ack_q                  <= 1'b0;
		end else begin
			primary_level_code_q   <= primary_level_code_d;
			alternate_level_code_q <= alternate_level_code_d;
			linCode_q              <= linCode_d;
			on_q                   <= on_d;
			fault_irq_unmask_q     <= fault_irq_unmask_d;
			output_discharge_bit_q <= output_discharge_bit_d;
			faultHeld_q            <= faultHeld_d;
			goodReadSeen_q         <= goodReadSeen_d;
			status_q               <= status_d;
			irqEn_q                <= irqEn_d;
			rdata_q                <= rdata_d;
			ack_q                  <= ack_d;
		end
	end

	always_comb begin
		for (int r = 0; r < NUM_BUCK; r++)
			activeLevelCode[r] = selSync_q[r] ? alternate_level_code_q[r]
				: primary_level_code_q[r];
	end
	assign linear_level_code = linCode_q;
	assign regulatorOn       = on_q;
	// Discharge only applies while the LDO is off
	assign dischargeOn       = output_discharge_bit_q & ~on_q[NUM_REG-1:NUM_BUCK];
	assign irq_out_n         = ~(|faultHeld_q);
	assign irq               = |(status_q & irqEn_q);

	genvar g;
	generate
		for (g = 0; g < NUM_BUCK; g++) begin : g_dec
			rcf_level_decode u_dec (
				.levelCode (activeLevelCode[g]),
				.levelMv   (levelMv[g])
			);
		end
	endgenerate

	// Any unmasked drop on a regulator that is on
	sequence s_faultStart;
		(|(fault_irq_unmask_q & faultRise));
	endsequence

	property p_irq_set;
		@(posedge sys_clk) disable iff (reset)
		s_faultStart |=> !irq_out_n;
	endproperty
	a_fault_raises_irq: assert property (p_irq_set) else $error("irq not raised");

	sequence s_noRead;
		!goodRead;
	endsequence
	a_irq_holds_unread: assert property (@(posedge sys_clk) disable iff (reset)
		(!irq_out_n && !goodRead && !(|goodReadSeen_q)) |=> !irq_out_n)
		else $error("irq released without read");

	a_irq_combine: assert property (@(posedge sys_clk) disable iff (reset)
		(|faultHeld_q) == !irq_out_n) else $error("irq mismatch");

	a_level_select: assert property (@(posedge sys_clk) disable iff (reset)
		selSync_q[1] |-> activeLevelCode[1] == alternate_level_code_q[1])
		else $error("wrong level bank");

	a_discharge_off: assert property (@(posedge sys_clk) disable iff (reset)
		on_q[NUM_BUCK] |-> !dischargeOn[0]) else $error("discharge while on");

	a_on_write: assert property (@(posedge sys_clk) disable iff (reset)
		(wrEn && avs_address == OFS_ON && avs_byteenable[1:0] == 2'b11)
		|=> regulatorOn == $past(avs_writedata[NUM_REG-1:0])) else $error("on bit not applied");

	a_sel_write: assert property (@(posedge sys_clk) disable iff (reset)
		(wrEn && avs_byteenable[0] && avs_address == OFS_ALT && selSync_q[0])
		|=> alternate_level_code_q[0] == $past(avs_writedata[CODE_W-1:0]))
		else $error("level write lost");

	a_good_read: assert property (@(posedge sys_clk) disable iff (reset)
		(rdEn && avs_address == OFS_GOOD) |=> avs_readdata[NUM_REG-1:0] == $past(okBits))
		else $error("good bits wrong");

	a_level_mv: assert property (@(posedge sys_clk) disable iff (reset)
		(activeLevelCode[0] == 6'h3f) |-> levelMv[0] == 12'd3900) else $error("decode wrong");

	a_held_no_read: assert property (@(posedge sys_clk) disable iff (reset)
		s_noRead |=> ((($past(faultHeld_q) & ~$past(goodReadSeen_q)) & ~faultHeld_q) == '0))
		else $error("fault released without a read");

	a_release_on_read: assert property (@(posedge sys_clk) disable iff (reset)
		goodRead |=> ((faultHeld_q & $past(faultHeld_q) & $past(goodNow)) == '0))
		else $error("fault kept after read and recovery");

	a_masked_quiet: assert property (@(posedge sys_clk) disable iff (reset)
		(irq_out_n && ((fault_irq_unmask_q & faultRise) == '0)) |=> irq_out_n)
		else $error("interrupt without unmasked fault");

	a_status_sticky: assert property (@(posedge sys_clk) disable iff (reset)
		s_faultStart |=> status_q[0])
		else $error("fault event not recorded");

	a_level_primary: assert property (@(posedge sys_clk) disable iff (reset)
		!selSync_q[1] |-> activeLevelCode[1] == primary_level_code_q[1])
		else $error("primary bank not used");

	a_bank_refused: assert property (@(posedge sys_clk) disable iff (reset)
		(wrEn && avs_address == OFS_ALT + 6'h01 && !selSync_q[1]) |=> $stable(alternate_level_code_q[1]))
		else $error("write to unselected bank applied");

	a_primary_write: assert property (@(posedge sys_clk) disable iff (reset)
		(wrEn && avs_byteenable[0] && avs_address == OFS_PRIMARY + 6'h01 && !selSync_q[1])
		|=> primary_level_code_q[1] == $past(avs_writedata[CODE_W-1:0]))
		else $error("primary level write lost");

	a_discharge_on: assert property (@(posedge sys_clk) disable iff (reset)
		(output_discharge_bit_q[0] && !on_q[NUM_BUCK]) |-> dischargeOn[0])
		else $error("discharge missing while off");

	a_discharge_idle: assert property (@(posedge sys_clk) disable iff (reset)
		!output_discharge_bit_q[0] |-> !dischargeOn[0])
		else $error("discharge without its bit");

	a_good_linear: assert property (@(posedge sys_clk) disable iff (reset)
		(rdEn && avs_address == OFS_GOOD)
		|=> avs_readdata[NUM_REG-1:NUM_BUCK] == ~$past(lowSync_q[NUM_REG-1:NUM_BUCK]))
		else $error("linear good bits wrong");

	a_single_wait: assert property (@(posedge sys_clk) disable iff (reset)
		((avs_read || avs_write) && !ack_q) |=> !avs_waitrequest)
		else $error("more than one wait state");
endmodule

/* bench/rcf_reg_plant.sv */
module rcf_reg_plant
	import rcf_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic [NUM_REG-1:0] regulatorOn,
	input  wire logic [NUM_REG-1:0] sagCmd,
	output logic      [NUM_REG-1:0] belowGoodRaw
);
	timeunit 1ns;
	timeprecision 1ps;
	// Off outputs collapse below threshold too, so faults clear via off path
	always @(posedge sys_clk) begin
		belowGoodRaw <= sagCmd | ~regulatorOn;
	end
endmodule

/* bench/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import rcf_pkg::*;
	logic                               sys_clk = 1'b0;
	logic                               reset = 1'b1;
	logic [ADDR_W-1:0]                  address = '0;
	logic                               rd = 1'b0;
	logic                               wr = 1'b0;
	logic [31:0]                        wdata = '0;
	logic [3:0]                         byteEn = 4'hf;
	logic [31:0]                        avs_readdata;
	logic                               avs_waitrequest;
	logic [NUM_BUCK-1:0]                selPin = '0;
	logic [NUM_REG-1:0]                 sagCmd = '0;
	logic [NUM_REG-1:0]                 belowGoodRaw;
	logic [NUM_BUCK-1:0][CODE_W-1:0]    activeLevelCode;
	logic [NUM_LDO-1:0][CODE_W-1:0]     linear_level_code;
	logic [NUM_REG-1:0]                 regulatorOn;
	logic [NUM_LDO-1:0]                 dischargeOn;
	logic                               irq_out_n;
	logic                               irq;
	logic [31:0]                        rdata;
	int                                 failures = 0;
	int                                 cmp_count = 0;

	always #5 sys_clk = ~sys_clk;

	rcf_top dut (.sys_clk(sys_clk), .reset(reset), .avs_address(address), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wdata), .avs_byteenable(byteEn), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .level_select_pin(selPin), .belowGoodRaw(belowGoodRaw),
		.activeLevelCode(activeLevelCode), .linear_level_code(linear_level_code), .regulatorOn(regulatorOn),
		.dischargeOn(dischargeOn), .irq_out_n(irq_out_n), .irq(irq));

	rcf_reg_plant plant (.sys_clk(sys_clk), .regulatorOn(regulatorOn), .sagCmd(sagCmd),
		.belowGoodRaw(belowGoodRaw));

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Waitrequest and read data taken at the rising edge, before the slave's flops move
	// One more edge after release, so outputs written at the accepting edge have settled
	task automatic access(input logic isWr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		address <= a;
		wdata   <= d;
		wr      <= isWr;
		rd      <= !isWr;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge sys_clk);
		rdata = avs_readdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		access(1'b0, a, 32'h0);
		chk(rdata, exp);
	endtask

	task automatic waitc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	initial begin
		waitc(4);
		reset <= 1'b0;
		rdchk(OFS_PRIMARY + 6'h01, {26'h0, RST_LEVEL});
		chk({26'h0, activeLevelCode[2]}, {26'h0, RST_LEVEL});
		rdchk(OFS_ON, 32'h00000fff);
		rdchk(6'h3f, UNMAPPED_DATA);
		access(1'b1, OFS_PRIMARY + 6'h01, 32'h0000002a);
		access(1'b1, OFS_ALT + 6'h01, 32'h00000005);
		chk({26'h0, activeLevelCode[1]}, 32'h0000002a);
		selPin <= 4'hf;
		waitc(4);
		chk({26'h0, activeLevelCode[1]}, {26'h0, RST_LEVEL});
		access(1'b1, OFS_ALT + 6'h01, 32'h00000005);
		chk({26'h0, activeLevelCode[1]}, 32'h00000005);
		rdchk(OFS_MV_BASE + 6'h01, 32'h000002d5);
		access(1'b1, OFS_ALT + 6'h02, 32'h0000003f);
		rdchk(OFS_MV_BASE + 6'h02, 32'h00000f3c);
		access(1'b1, OFS_ALT + 6'h03, 32'h0000001f);
		rdchk(OFS_MV_BASE + 6'h03, 32'h0000060e);
		access(1'b1, OFS_ALT, 32'h0000003f);
		chk({26'h0, activeLevelCode[0]}, 32'h0000003f);
		rdchk(OFS_MV_BASE, 32'h00000f3c);
		access(1'b1, OFS_LINEAR + 6'h03, 32'h00000011);
		chk({26'h0, linear_level_code[3]}, 32'h00000011);
		access(1'b1, OFS_DISCH, 32'h00000001);
		access(1'b1, OFS_ON, 32'h00000fef);
		chk({20'h0, regulatorOn}, 32'h00000fef);
		chk({24'h0, dischargeOn}, 32'h00000001);
		access(1'b1, OFS_DISCH, 32'h00000000);
		chk({24'h0, dischargeOn}, 32'h00000000);
		access(1'b1, OFS_ON, 32'h00000fff);
		access(1'b1, OFS_UNMASK, 32'h00000024);
		sagCmd <= 12'h008;
		waitc(6);
		chk({31'h0, irq_out_n}, 32'h1);
		rdchk(OFS_GOOD, 32'h00000ff7);
		sagCmd <= 12'h004;
		waitc(6);
		chk({31'h0, irq_out_n}, 32'h0);
		sagCmd <= 12'h000;
		waitc(6);
		chk({31'h0, irq_out_n}, 32'h0);
		rdchk(OFS_GOOD, 32'h00000fff);
		waitc(3);
		chk({31'h0, irq_out_n}, 32'h1);
		rdchk(OFS_STATUS, 32'h00000003);
		access(1'b1, OFS_IRQ_EN, 32'h00000001);
		waitc(2);
		chk({31'h0, irq}, 32'h1);
		access(1'b1, OFS_IRQ_EN, 32'h00000000);
		waitc(2);
		chk({31'h0, irq}, 32'h0);
		access(1'b1, OFS_IRQ_CLR, 32'h00000003);
		access(1'b1, OFS_IRQ_EN, 32'h00000003);
		waitc(2);
		chk({31'h0, irq}, 32'h0);
		rdchk(OFS_STATUS, 32'h00000000);
		sagCmd <= 12'h020;
		waitc(6);
		chk({31'h0, irq_out_n}, 32'h0);
		rdchk(OFS_GOOD, 32'h00000fdf);
		sagCmd <= 12'h024;
		access(1'b1, OFS_ON, 32'h00000fdf);
		waitc(6);
		chk({31'h0, irq_out_n}, 32'h0);
		sagCmd <= 12'h000;
		waitc(4);
		chk({31'h0, irq_out_n}, 32'h0);
		rdchk(OFS_GOOD, 32'h00000fdf);
		waitc(3);
		chk({31'h0, irq_out_n}, 32'h1);
		conclude();
	end

	initial begin
		waitc(3000);
		failures++;
		conclude();
	end
endmodule
